/* logic/wkd_map.vh */
// Register map, field layout, reset values and timing constants for the wake detector.
//
// Functional notes
// [RULE_01] Three wake inputs, each separately configured.
// [RULE_02] Rising and falling crossings both reported.
// [RULE_03] Interrupt in normal/stop, wake in sleep/fail-safe.
// [RULE_04] Static always monitored; cyclic only in window.
// [RULE_05] Crossing back before filter expiry discards event.
// [RULE_06] Filter field selects static/cyclic and filter time.
// [RULE_07] Per-pin wake enable written by host.
// [RULE_08] Per-pin wake-source flag, readable any mode.
// [RULE_09] Pin levels readable in normal/stop always.
// [RULE_10] Cyclic sense shows level sampled in window.
// [RULE_11] Failure-output wake inputs: fixed 16 us, own status.
// [RULE_12] Bias field: none, pull-down, pull-up, automatic.
// [RULE_13] Automatic bias follows detected input level.
// [RULE_14] Measurement bit gates inputs one and two; the code gates them only in normal mode.
// [RULE_15] Synchronise comparators; count filter in clock cycles.
`ifndef WKD_MAP_VH
`define WKD_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define WKD_OFF_WAKE_EN 12'h000
`define WKD_OFF_BIAS 12'h004
`define WKD_OFF_FILTER 12'h008
`define WKD_OFF_SOURCE 12'h00c
`define WKD_OFF_LEVEL 12'h010
`define WKD_OFF_ALT_STAT 12'h014
`define WKD_OFF_MISC 12'h018
`define WKD_OFF_IRQ_STAT 12'h01c
`define WKD_OFF_IRQ_MASK 12'h020

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define WKD_MISC_MEAS_BIT 0
`define WKD_MISC_FO_LSB 1
`define WKD_RST_WAKE_EN 3'h0
`define WKD_RST_BIAS 6'h00
`define WKD_RST_FILTER 6'h00
`define WKD_RST_MISC 3'h0
`define WKD_RST_IRQ_MASK 5'h00
`define WKD_BIAS_NONE 2'h0
`define WKD_BIAS_DOWN 2'h1
`define WKD_BIAS_UP 2'h2
`define WKD_BIAS_AUTO 2'h3
`define WKD_FLT_STATIC_SHORT 2'h0
`define WKD_FLT_STATIC_LONG 2'h1
`define WKD_FLT_CYCLIC_T1 2'h2
`define WKD_FLT_CYCLIC_T2 2'h3
`define WKD_MODE_NORMAL 2'h0
`define WKD_MODE_STOP 2'h1
`define WKD_MODE_SLEEP 2'h2
`define WKD_MODE_FAILSAFE 2'h3

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define WKD_CLK_PERIOD_PS 4000
`define WKD_FILT_SHORT_NS 16000
`define WKD_FILT_LONG_NS 64000
`define WKD_FILT_SHORT_CYC (`WKD_FILT_SHORT_NS * 1000 / `WKD_CLK_PERIOD_PS)
`define WKD_FILT_LONG_CYC (`WKD_FILT_LONG_NS * 1000 / `WKD_CLK_PERIOD_PS)

`endif

/* logic/wkd_input_filter.v */
// Synchroniser and glitch filter for one wake comparator output.
`timescale 1ns/1ps
`default_nettype none

module wkd_input_filter #(
    parameter CNT_W = 16,
    parameter [CNT_W-1:0] SHORT_CYC = 16'd4000,
    parameter [CNT_W-1:0] LONG_CYC = 16'd16000
) (
    input wire pclk,
    input wire presetn,
    input wire pin_in,
    input wire active,
    input wire long_sel,
    output wire lvl_sync,
    output reg lvl_stable,
    output reg edge_evt
);

    reg sync_a;
    reg sync_b;
    reg [CNT_W-1:0] cnt;
    wire [CNT_W-1:0] limit;

    assign lvl_sync = sync_b;
    assign limit = long_sel ? LONG_CYC : SHORT_CYC;

    // ------------------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end
        else
        begin
            sync_a <= pin_in; // RULE_15
            sync_b <= sync_a;
        end
    end

    // ------------------------------------------------------------------------
    // Filter
    // ------------------------------------------------------------------------
    // Outside the active window the count restarts, so a cyclic input must
    // stay changed for a whole filter time inside one window.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= {CNT_W{1'b0}};
            lvl_stable <= 1'b0;
            edge_evt <= 1'b0;
        end
        else
        begin
            edge_evt <= 1'b0;
            if (!active || sync_b == lvl_stable)
            begin
                cnt <= {CNT_W{1'b0}}; // RULE_04 RULE_05
            end
            else if (cnt >= limit - 1'b1)
            begin
                cnt <= {CNT_W{1'b0}};
                lvl_stable <= sync_b;
                edge_evt <= 1'b1; // RULE_02
            end
            else
            begin
                cnt <= cnt + 1'b1; // RULE_15
            end
        end
    end

endmodule

`default_nettype wire

/* logic/wkd_wake_detector.v */
// Wake input detector with APB register access and interrupt.
`timescale 1ns/1ps
`default_nettype none
`include "wkd_map.vh"

module wkd_wake_detector #(
    parameter [15:0] FILT_SHORT_CYC = `WKD_FILT_SHORT_CYC,
    parameter [15:0] FILT_LONG_CYC = `WKD_FILT_LONG_CYC
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [2:0] wake_pin,
    input wire [1:0] fo_pin,
    input wire [1:0] dev_mode,
    input wire timer_one_on,
    input wire timer_two_on,
    output wire [2:0] pull_up_en,
    output wire [2:0] pull_down_en,
    output wire meas_switch,
    output reg wake_req,
    output wire irq
);

    // ------------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------------
    // Sticky clear-by-one; a new event in the clearing cycle stays set.
    function [4:0] next_w1c;
        input [4:0] cur;
        input [4:0] clr;
        input [4:0] set;
        begin
            next_w1c = (cur & ~clr) | set;
        end
    endfunction

    // Bias decode: returns {pull_up, pull_down}.
    function [1:0] bias_dec;
        input [1:0] sel;
        input lvl;
        input gate;
        begin
            if (gate)
            begin
                bias_dec = 2'b00;
            end
            else
            begin
                case (sel)
                    `WKD_BIAS_NONE: bias_dec = 2'b00;
                    `WKD_BIAS_DOWN: bias_dec = 2'b01;
                    `WKD_BIAS_UP: bias_dec = 2'b10;
                    `WKD_BIAS_AUTO: bias_dec = lvl ? 2'b10 : 2'b01;
                    default: bias_dec = 2'b00;
                endcase
            end
        end
    endfunction

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    reg [2:0] wake_enable_ctrl;
    reg [5:0] bias_current_ctrl;
    reg [5:0] detect_filter_ctrl;
    reg [2:0] wake_source_status;
    reg [2:0] pin_level_status;
    reg [1:0] alt_input_wake_status;
    reg [2:0] misc_ctrl;
    reg [4:0] irq_status;
    reg [4:0] irq_mask;

    wire measure_path_enable;
    wire [1:0] fo_wake_en;
    wire mode_awake;
    wire mode_normal;
    wire meas_gate;

    assign measure_path_enable = misc_ctrl[`WKD_MISC_MEAS_BIT];
    assign fo_wake_en = misc_ctrl[`WKD_MISC_FO_LSB+1:`WKD_MISC_FO_LSB];
    assign mode_normal = (dev_mode == `WKD_MODE_NORMAL);
    assign mode_awake = mode_normal || (dev_mode == `WKD_MODE_STOP);
    assign meas_gate = measure_path_enable && mode_normal; // RULE_14
    assign meas_switch = meas_gate;

    // ------------------------------------------------------------------------
    // Input channels: three wake pins, then two failure-output pins
    // ------------------------------------------------------------------------
    wire [4:0] ch_pin;
    wire [4:0] ch_active;
    wire [4:0] ch_long;
    wire [4:0] ch_sync;
    wire [4:0] ch_stable;
    wire [4:0] ch_evt;
    wire [4:0] ch_gate;
    wire [4:0] ch_en;
    wire [2:0] ch_cyclic;

    assign ch_pin = {fo_pin, wake_pin};
    assign ch_gate = {3'b000, meas_gate, meas_gate}; // RULE_14
    assign ch_en = {fo_wake_en, wake_enable_ctrl}; // RULE_07

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_wk
            wire [1:0] fsel;
            wire [1:0] bias;
            assign fsel = detect_filter_ctrl[2*g+1:2*g];
            // RULE_06
            assign ch_cyclic[g] = fsel[1];
            assign ch_long[g] = (fsel == `WKD_FLT_STATIC_LONG);
            assign ch_active[g] = (fsel == `WKD_FLT_CYCLIC_T1) ? timer_one_on :
                (fsel == `WKD_FLT_CYCLIC_T2) ? timer_two_on : 1'b1; // RULE_04
            assign bias = bias_dec(bias_current_ctrl[2*g+1:2*g], ch_stable[g],
                ch_gate[g]); // RULE_12 RULE_13
            assign pull_up_en[g] = bias[1];
            assign pull_down_en[g] = bias[0];
        end
    endgenerate

    // Failure-output inputs run static with the short filter.
    assign ch_active[4:3] = 2'b11; // RULE_11
    assign ch_long[4:3] = 2'b00;

    generate
        for (g = 0; g < 5; g = g + 1)
        begin : g_flt
            wkd_input_filter #(
                .CNT_W(16),
                .SHORT_CYC(FILT_SHORT_CYC),
                .LONG_CYC(FILT_LONG_CYC)
            ) u_flt (
                .pclk(pclk),
                .presetn(presetn),
                .pin_in(ch_pin[g]),
                .active(ch_active[g]),
                .long_sel(ch_long[g]),
                .lvl_sync(ch_sync[g]),
                .lvl_stable(ch_stable[g]),
                .edge_evt(ch_evt[g])
            ); // RULE_01
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Event routing
    // ------------------------------------------------------------------------
    wire [4:0] ev_ok;
    wire [4:0] irq_set;
    wire [2:0] src_set;
    wire [1:0] alt_set;
    wire [2:0] lvl_now;

    assign ev_ok = ch_evt & ch_en & ~ch_gate;
    assign irq_set = mode_awake ? ev_ok : 5'h00; // RULE_03
    assign src_set = ev_ok[2:0]; // RULE_08
    assign alt_set = ev_ok[4:3]; // RULE_11
    // Static sense shows the live level; cyclic sense holds the window sample.
    assign lvl_now = (ch_cyclic & ch_stable[2:0]) | (~ch_cyclic & ch_sync[2:0]); // RULE_10

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wake_req <= 1'b0;
            pin_level_status <= 3'h0;
        end
        else
        begin
            wake_req <= !mode_awake && (|ev_ok); // RULE_03
            if (mode_awake)
            begin
                // Gated inputs keep their last level while measuring.
                pin_level_status <= (pin_level_status & ch_gate[2:0]) |
                    (lvl_now & ~ch_gate[2:0]); // RULE_09 RULE_14
            end
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ------------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------------
    // One wait state: pready rises in the second access cycle, so read data
    // always comes from a flop loaded in the first.
    wire acc;
    wire wr;
    wire [4:0] clr_src;
    wire [4:0] clr_irq;
    reg hit;
    reg [31:0] rd_val;

    assign acc = psel && penable && !pready;
    assign wr = psel && penable && pready && pwrite;
    assign clr_src = (wr && paddr == `WKD_OFF_SOURCE) ? {2'b00, pwdata[2:0]} :
        (wr && paddr == `WKD_OFF_ALT_STAT) ? {pwdata[1:0], 3'b000} : 5'h00;
    assign clr_irq = (wr && paddr == `WKD_OFF_IRQ_STAT) ? pwdata[4:0] : 5'h00;

    always @*
    begin
        hit = 1'b1;
        rd_val = 32'h0000_0000;
        case (paddr)
            `WKD_OFF_WAKE_EN: rd_val[2:0] = wake_enable_ctrl;
            `WKD_OFF_BIAS: rd_val[5:0] = bias_current_ctrl;
            `WKD_OFF_FILTER: rd_val[5:0] = detect_filter_ctrl;
            `WKD_OFF_SOURCE: rd_val[2:0] = wake_source_status;
            `WKD_OFF_LEVEL: rd_val[2:0] = pin_level_status;
            `WKD_OFF_ALT_STAT: rd_val[1:0] = alt_input_wake_status;
            `WKD_OFF_MISC: rd_val[2:0] = misc_ctrl;
            `WKD_OFF_IRQ_STAT: rd_val[4:0] = irq_status;
            `WKD_OFF_IRQ_MASK: rd_val[4:0] = irq_mask;
            default: hit = 1'b0;
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= acc;
            pslverr <= acc && !hit;
            if (acc && !pwrite)
            begin
                prdata <= rd_val;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Control and status registers
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wake_enable_ctrl <= `WKD_RST_WAKE_EN;
            bias_current_ctrl <= `WKD_RST_BIAS;
            detect_filter_ctrl <= `WKD_RST_FILTER;
            misc_ctrl <= `WKD_RST_MISC;
            irq_mask <= `WKD_RST_IRQ_MASK;
        end
        else if (wr)
        begin
            case (paddr)
                `WKD_OFF_WAKE_EN: wake_enable_ctrl <= pwdata[2:0]; // RULE_07
                `WKD_OFF_BIAS: bias_current_ctrl <= pwdata[5:0]; // RULE_12
                `WKD_OFF_FILTER: detect_filter_ctrl <= pwdata[5:0]; // RULE_06
                `WKD_OFF_MISC: misc_ctrl <= pwdata[2:0];
                `WKD_OFF_IRQ_MASK: irq_mask <= pwdata[4:0];
                default: misc_ctrl <= misc_ctrl;
            endcase
        end
    end

    wire [4:0] next_src;
    wire [4:0] next_irq;

    assign next_src = next_w1c({alt_input_wake_status, wake_source_status}, clr_src,
        {alt_set, src_set});
    assign next_irq = next_w1c(irq_status, clr_irq, irq_set);

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wake_source_status <= 3'h0;
            alt_input_wake_status <= 2'h0;
            irq_status <= 5'h00;
        end
        else
        begin
            wake_source_status <= next_src[2:0]; // RULE_08
            alt_input_wake_status <= next_src[4:3]; // RULE_11
            irq_status <= next_irq; // RULE_03
        end
    end

endmodule

`default_nettype wire

/* tb/wkd_props.sv */
// Port-level assertions for the wake detector.
`timescale 1ns/1ps
`default_nettype none
module wkd_props #(
    parameter [15:0] FILT_SHORT_CYC = 16'd8,
    parameter [15:0] FILT_LONG_CYC = 16'd32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [2:0] wake_pin,
    input wire logic [1:0] fo_pin,
    input wire logic [1:0] dev_mode,
    input wire logic [2:0] pull_up_en,
    input wire logic [2:0] pull_down_en,
    input wire logic meas_switch,
    input wire logic wake_req,
    input wire logic irq
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Cycles since any pin moved; it saturates so a long quiet spell never wraps to zero.
    logic [15:0] quiet;
    logic [4:0] pins_q;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            quiet <= 16'h0000;
            pins_q <= 5'h00;
        end
        else
        begin
            pins_q <= {fo_pin, wake_pin};
            if ({fo_pin, wake_pin} != pins_q)
                quiet <= 16'h0000;
            else if (quiet != 16'hffff)
                quiet <= quiet + 16'h0001;
        end
    // ----
    // Assertions
    // ----
    chk_ready_once: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("access phase not two cycles");
    chk_map_error: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h020))
        else $error("pslverr wrong for address");
    chk_wake_mode: assert property (wake_req |-> $past(dev_mode) >= 2'h2)
        else $error("wake request outside low power");
    chk_wake_pulse: assert property (wake_req |=> !wake_req)
        else $error("wake request not one cycle");
    chk_wake_filter: assert property (wake_req |-> quiet >= FILT_SHORT_CYC - 16'h0002)
        else $error("wake before filter time");
    chk_bias_excl: assert property ((pull_up_en & pull_down_en) == 3'h0)
        else $error("pull-up and pull-down together");
    chk_meas_mode: assert property (meas_switch |-> dev_mode == 2'h0)
        else $error("measure switch outside normal");
    chk_meas_bias: assert property (meas_switch |-> (pull_up_en[1:0] | pull_down_en[1:0]) == 2'h0)
        else $error("bias on gated inputs");
    chk_irq_sticky: assert property ($fell(irq) |-> $past(pready) && $past(pwrite))
        else $error("irq dropped without a write");
endmodule
bind wkd_wake_detector wkd_props #(
    .FILT_SHORT_CYC(FILT_SHORT_CYC),
    .FILT_LONG_CYC(FILT_LONG_CYC)
) i_wkd_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .wake_pin(wake_pin), .fo_pin(fo_pin),
    .dev_mode(dev_mode), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
    .meas_switch(meas_switch), .wake_req(wake_req), .irq(irq)
);
`default_nettype wire

/* tb/wkd_pin_model.sv */
// Switches that drive the wake and failure-output pins.
`timescale 1ns/1ps
`default_nettype none
module wkd_pin_model (
    input wire logic pclk,
    output logic [2:0] wake_pin,
    output logic [1:0] fo_pin
);
    initial
    begin
        wake_pin = 3'h0;
        fo_pin = 2'h0;
    end
    task automatic drive(input logic [2:0] w, input logic [1:0] f);
        wake_pin <= w;
        fo_pin <= f;
    endtask
    // A contact bounce shorter than the filter; it must leave no trace.
    task automatic bounce(input int idx, input int cyc);
        wake_pin[idx] <= ~wake_pin[idx];
        repeat (cyc) @(posedge pclk);
        wake_pin[idx] <= ~wake_pin[idx];
    endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the wake detector.
`timescale 1ns/1ps
`default_nettype none
`include "wkd_map.vh"
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [1:0] dev_mode = 2'h0;
    logic timer_one_on = 1'b0;
    logic timer_two_on = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, meas_switch, wake_req, irq, rerr;
    logic [2:0] wake_pin, pull_up_en, pull_down_en;
    logic [1:0] fo_pin;
    int err_count = 0;
    int check_count = 0;
    always #2 pclk = ~pclk;
    wkd_wake_detector #(.FILT_SHORT_CYC(16'd8), .FILT_LONG_CYC(16'd32)) i_wkd_wake_detector (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wake_pin(wake_pin), .fo_pin(fo_pin), .dev_mode(dev_mode),
        .timer_one_on(timer_one_on), .timer_two_on(timer_two_on), .pull_up_en(pull_up_en),
        .pull_down_en(pull_down_en), .meas_switch(meas_switch), .wake_req(wake_req), .irq(irq)
    );
    wkd_pin_model i_wkd_pin_model (.pclk(pclk), .wake_pin(wake_pin), .fo_pin(fo_pin));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // The request stands until pready is seen high at a rising edge; only the
    // watchdog ends a wait that never completes.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic wrap_up;
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_reset;
        check({irq, wake_req, meas_switch, pull_up_en, pull_down_en}, 32'h0);
        rchk(`WKD_OFF_WAKE_EN, 32'h0);
        rchk(`WKD_OFF_BIAS, 32'h0);
        rchk(`WKD_OFF_FILTER, 32'h0);
        rchk(`WKD_OFF_MISC, 32'h0);
        apb(1'b0, 12'h040, 32'h0);
        check(rerr, 32'h1);
    endtask
    task automatic t_static;
        wr(`WKD_OFF_WAKE_EN, 32'h3);
        wr(`WKD_OFF_IRQ_MASK, 32'h1f);
        i_wkd_pin_model.bounce(0, 4);
        cyc(20);
        rchk(`WKD_OFF_SOURCE, 32'h0);
        i_wkd_pin_model.drive(3'h5, 2'h0);
        cyc(14);
        rchk(`WKD_OFF_SOURCE, 32'h1);
        rchk(`WKD_OFF_LEVEL, 32'h5);
        check(irq, 32'h1);
        wr(`WKD_OFF_IRQ_MASK, 32'h0);
        check(irq, 32'h0);
        wr(`WKD_OFF_IRQ_MASK, 32'h1f);
        wr(`WKD_OFF_IRQ_STAT, 32'h1f);
        check(irq, 32'h0);
        wr(`WKD_OFF_SOURCE, 32'h1);
        rchk(`WKD_OFF_SOURCE, 32'h0);
        i_wkd_pin_model.drive(3'h4, 2'h0);
        cyc(14);
        rchk(`WKD_OFF_SOURCE, 32'h1);
    endtask
    task automatic t_long;
        wr(`WKD_OFF_WAKE_EN, 32'h7);
        wr(`WKD_OFF_FILTER, 32'h4);
        wr(`WKD_OFF_SOURCE, 32'h7);
        i_wkd_pin_model.drive(3'h6, 2'h0);
        cyc(20);
        rchk(`WKD_OFF_SOURCE, 32'h0);
        cyc(20);
        rchk(`WKD_OFF_SOURCE, 32'h2);
    endtask
    task automatic t_cyclic;
        wr(`WKD_OFF_FILTER, 32'h32);
        wr(`WKD_OFF_SOURCE, 32'h7);
        i_wkd_pin_model.drive(3'h3, 2'h0);
        cyc(20);
        rchk(`WKD_OFF_SOURCE, 32'h0);
        rchk(`WKD_OFF_LEVEL, 32'h6);
        timer_one_on <= 1'b1;
        cyc(14);
        timer_one_on <= 1'b0;
        rchk(`WKD_OFF_SOURCE, 32'h1);
        timer_two_on <= 1'b1;
        cyc(14);
        timer_two_on <= 1'b0;
        rchk(`WKD_OFF_SOURCE, 32'h5);
        i_wkd_pin_model.drive(3'h2, 2'h0);
        cyc(14);
        rchk(`WKD_OFF_LEVEL, 32'h3);
        wr(`WKD_OFF_FILTER, 32'h0);
        cyc(14);
        wr(`WKD_OFF_SOURCE, 32'h7);
        wr(`WKD_OFF_IRQ_STAT, 32'h1f);
    endtask
    task automatic t_sleep;
        int n;
        for (int m = 2; m < 4; m++)
        begin
            n = 0;
            dev_mode <= m[1:0];
            i_wkd_pin_model.drive(wake_pin ^ 3'h4, 2'h0);
            do
                @(negedge pclk);
            while (wake_req !== 1'b1 && ++n < 40);
            check(wake_req, 32'h1);
            @(posedge pclk);
            rchk(`WKD_OFF_IRQ_STAT, 32'h0);
            rchk(`WKD_OFF_SOURCE, 32'h4);
            wr(`WKD_OFF_SOURCE, 32'h4);
        end
        dev_mode <= 2'h0;
    endtask
    task automatic t_bias;
        for (int c = 0; c < 4; c++)
        begin
            wr(`WKD_OFF_BIAS, c << 4);
            check({pull_up_en[2], pull_down_en[2]}, {c == 2, c == 1 || c == 3});
        end
        i_wkd_pin_model.drive(3'h6, 2'h0);
        cyc(14);
        check({pull_up_en[2], pull_down_en[2]}, 32'h2);
    endtask
    task automatic t_meas;
        wr(`WKD_OFF_BIAS, 32'h32);
        check(pull_up_en[0], 32'h1);
        wr(`WKD_OFF_MISC, 32'h1);
        check({meas_switch, pull_up_en[0]}, 32'h2);
        wr(`WKD_OFF_SOURCE, 32'h7);
        i_wkd_pin_model.drive(3'h7, 2'h0);
        cyc(14);
        rchk(`WKD_OFF_SOURCE, 32'h0);
        rchk(`WKD_OFF_LEVEL, 32'h6);
        dev_mode <= 2'h1;
        cyc(2);
        check(meas_switch, 32'h0);
        dev_mode <= 2'h0;
        wr(`WKD_OFF_MISC, 32'h6);
        cyc(14);
        wr(`WKD_OFF_SOURCE, 32'h7);
        wr(`WKD_OFF_IRQ_STAT, 32'h1f);
    endtask
    task automatic t_fo;
        wr(`WKD_OFF_FILTER, 32'h15);
        i_wkd_pin_model.drive(3'h7, 2'h1);
        cyc(14);
        rchk(`WKD_OFF_ALT_STAT, 32'h1);
        rchk(`WKD_OFF_IRQ_STAT, 32'h8);
        wr(`WKD_OFF_ALT_STAT, 32'h1);
        rchk(`WKD_OFF_ALT_STAT, 32'h0);
    endtask
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_static();
        t_long();
        t_cyclic();
        t_sleep();
        t_bias();
        t_meas();
        t_fo();
        wrap_up();
    end
    // The whole run needs well under a thousand cycles; this only cuts a hang short.
    initial
    begin
        #20000;
        err_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
